// *** exec_unit_pkg.sv ***
// Constants, opcodes and types for the shift, logic, compare and branch unit.
// Assumes a single 125 MHz clock and a sequencer that decodes instructions.
`default_nettype none

package exec_unit_pkg;

    localparam int WORD_W = 24;
    localparam int CNT_W = 6;
    localparam int INDEX_W = 14;
    localparam int STATE_W = 10;
    localparam int ADDR_W = 14;
    localparam int REG_ADDR_W = 4;
    localparam int STEPS_W = 5;

    // Major opcodes that this unit recognises on the opcode port (octal 01, 21, 26, 27)
    localparam logic [5:0] OPC_BRANCH = 6'h01;
    localparam logic [5:0] OPC_XOR = 6'h11;
    localparam logic [5:0] OPC_AND = 6'h16;
    localparam logic [5:0] OPC_OR = 6'h17;

    // Cycle figures
    localparam logic [STEPS_W-1:0] SHIFT_BASE_CYC = 5'h02;
    localparam logic [CNT_W:0] SHIFT_KNEE = 7'h09;
    localparam logic [CNT_W:0] SHIFT_STEP = 7'h05;
    localparam logic [STEPS_W-1:0] LOGIC_CYC = 5'h02;
    localparam logic [STEPS_W-1:0] COMPARE_CYC = 5'h02;
    localparam logic [STEPS_W-1:0] SINGLE_CYC = 5'h01;

    // Bit positions
    localparam int SIGN_BIT = 23;
    localparam int SIGN_NEXT = 22;
    localparam int SENSE_LO = 0;
    localparam int IE_BIT = 8;
    localparam int OV_BIT = 9;
    localparam int RESTORE_OV = 23;
    localparam int RESTORE_GT = 22;
    localparam int RESTORE_LT = 21;
    localparam int RESTORE_EQ = 20;
    localparam int RESTORE_BM = 19;

    // Register port map (word indexes)
    localparam logic [REG_ADDR_W-1:0] REG_FLAGS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_ACC = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_EXT = 4'h2;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h3;

    // Flag register layout: sense 7:0, ie 8, ov 9, gt 10, eq 11, lt 12, bit match 13
    localparam int FL_GT = 10;
    localparam int FL_EQ = 11;
    localparam int FL_LT = 12;
    localparam int FL_BM = 13;
    localparam int FLAGS_W = 14;

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RST = 24'h00_0000;
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 14'h0000;

    // Functions for instructions whose major opcode is decoded by the sequencer
    typedef enum logic [4:0] {
        FN_NONE,
        FN_ARITH_RIGHT_SHIFT,
        FN_LOGICAL_RIGHT_SHIFT,
        FN_ROTATE_LEFT,
        FN_END_OFF_LEFT_SHIFT,
        FN_DOUBLE_ARITH_RIGHT,
        FN_DOUBLE_LOGICAL_RIGHT_SHIFT,
        FN_DOUBLE_ROTATE_LEFT,
        FN_DOUBLE_LEFT_SHIFT,
        FN_MASKED_REPLACE,
        FN_SET_STATE_OP,
        FN_CLEAR_STATE_OP,
        FN_COMPARE_MEMORY,
        FN_BRANCH_THEN_HALT
    } func_t;

    typedef enum logic [4:0] {
        OP_IDLE, OP_ARS, OP_LRS, OP_ROL, OP_LSL, OP_DARS, OP_DLRS, OP_DROL, OP_DLSL,
        OP_RUM, OP_XOR, OP_AND, OP_OR, OP_SET, OP_CLR, OP_CMP, OP_BAH, OP_BRU
    } op_t;

endpackage : exec_unit_pkg

`default_nettype wire

// *** exec_unit.sv ***
// Shift, logical, state-control, compare and branch execution for a 24-bit CPU.
// Assumes the sequencer supplies decoded fields with a one-cycle start pulse,
// and a memory data path that presents the operand word alongside it.
//
// How it works
// - Indexed shift: count plus selected index
// - Shift takes 2 + int((count-9)/5) cycles above a count of 9, else 2
// - Arithmetic right: keep sign, copy into 22
// - Logical right: zeros enter accumulator bit 23
// - Rotate left: bit 23 feeds bit 0
// - End-off left: zeros in, top bits lost
// - Double arithmetic right: sign held, A0 to E23
// - Double logical right: zeros at top, E0 lost
// - Double rotate: 48-bit ring through both registers
// - Double left: E23 to A0, zeros at E0
// - Masked replace: operand bits where extension set
// - Xor, and, or into accumulator, two cycles
// - State operand: low ten bits plus index
// - Set or clear selected flip-flops, one cycle
// - Compare sets greater, equal or less, two cycles
// - Compare sets bit match on common ones
// - Branch then halt until start switch
// - Unconditional branch, one cycle, indexed or indirect
// - Indirect branch restores five indicators from word
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module exec_unit
    import exec_unit_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Sequencer request
    input wire logic start,
    input wire logic [5:0] opcode,
    input wire func_t func,
    input wire logic [CNT_W-1:0] count_field,
    input wire logic [STATE_W-1:0] state_field,
    input wire logic index_en,
    input wire logic [INDEX_W-1:0] selected_index,
    input wire logic indirect,
    input wire logic [ADDR_W-1:0] eff_addr,
    // Memory data path
    input wire logic [WORD_W-1:0] mem_operand,
    // Console start switch, asynchronous
    input wire logic start_switch,
    // Register port
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [WORD_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WORD_W-1:0] reg_rdata,
    // Results
    output logic busy,
    output logic done,
    output logic branch_take,
    output logic [ADDR_W-1:0] branch_addr,
    output logic halted,
    output logic [WORD_W-1:0] acc,
    output logic [WORD_W-1:0] ext,
    output logic [FLAGS_W-1:0] flags
);

    // One single-bit step of a shift on the 48-bit pair {a, e}
    function automatic logic [2*WORD_W-1:0] shift_step(input op_t k,
                                                       input logic [2*WORD_W-1:0] ae);
        logic [WORD_W-1:0] a;
        logic [WORD_W-1:0] e;
        a = ae[2*WORD_W-1:WORD_W];
        e = ae[WORD_W-1:0];
        case (k)
            OP_ARS: a = {a[SIGN_BIT], a[SIGN_BIT], a[SIGN_NEXT:1]};
            OP_LRS: a = {1'b0, a[WORD_W-1:1]};
            OP_ROL: a = {a[WORD_W-2:0], a[WORD_W-1]};
            OP_LSL: a = {a[WORD_W-2:0], 1'b0};
            OP_DARS: begin
                e = {a[0], e[WORD_W-1:1]};
                a = {a[SIGN_BIT], a[SIGN_BIT], a[SIGN_NEXT:1]};
            end
            OP_DLRS: begin
                e = {a[0], e[WORD_W-1:1]};
                a = {1'b0, a[WORD_W-1:1]};
            end
            OP_DROL: begin
                {a, e} = {a[WORD_W-2:0], e, a[WORD_W-1]};
            end
            OP_DLSL: begin
                {a, e} = {a[WORD_W-2:0], e, 1'b0};
            end
            default: begin
                a = ae[2*WORD_W-1:WORD_W];
            end
        endcase
        return {a, e};
    endfunction : shift_step

    // Whole shift, one bit position per step until the count runs out
    function automatic logic [2*WORD_W-1:0] shift_all(input op_t k,
                                                      input logic [2*WORD_W-1:0] ae,
                                                      input logic [CNT_W:0] n);
        logic [2*WORD_W-1:0] r;
        r = ae;
        for (int i = 0; i < (1 << (CNT_W + 1)); i++) begin
            if (i < int'(n)) begin
                r = shift_step(k, r);
            end
        end
        return r;
    endfunction : shift_all

    // Cycle length of a shift for a given effective count
    function automatic logic [STEPS_W-1:0] shift_cycles(input logic [CNT_W:0] n);
        logic [CNT_W:0] extra;
        extra = (n > SHIFT_KNEE) ? (CNT_W + 1)'((n - SHIFT_KNEE) / SHIFT_STEP) : '0;
        return SHIFT_BASE_CYC + STEPS_W'(extra);
    endfunction : shift_cycles

    // Start switch synchroniser and edge detect
    logic sw_meta_reg;
    logic sw_sync_reg;
    logic sw_prev_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sw_meta_reg <= 1'b0;
            sw_sync_reg <= 1'b0;
            sw_prev_reg <= 1'b0;
        end else begin
            sw_meta_reg <= start_switch;
            sw_sync_reg <= sw_meta_reg;
            sw_prev_reg <= sw_sync_reg;
        end
    end

    logic sw_press;
    assign sw_press = sw_sync_reg & ~sw_prev_reg;

    // Decode of the request
    op_t op_next;

    always_comb begin
        op_next = OP_IDLE;
        if (opcode == OPC_XOR) begin
            op_next = OP_XOR;
        end else if (opcode == OPC_AND) begin
            op_next = OP_AND;
        end else if (opcode == OPC_OR) begin
            op_next = OP_OR;
        end else if (opcode == OPC_BRANCH) begin
            op_next = OP_BRU;
        end else begin
            case (func)
                FN_ARITH_RIGHT_SHIFT: op_next = OP_ARS;
                FN_LOGICAL_RIGHT_SHIFT: op_next = OP_LRS;
                FN_ROTATE_LEFT: op_next = OP_ROL;
                FN_END_OFF_LEFT_SHIFT: op_next = OP_LSL;
                FN_DOUBLE_ARITH_RIGHT: op_next = OP_DARS;
                FN_DOUBLE_LOGICAL_RIGHT_SHIFT: op_next = OP_DLRS;
                FN_DOUBLE_ROTATE_LEFT: op_next = OP_DROL;
                FN_DOUBLE_LEFT_SHIFT: op_next = OP_DLSL;
                FN_MASKED_REPLACE: op_next = OP_RUM;
                FN_SET_STATE_OP: op_next = OP_SET;
                FN_CLEAR_STATE_OP: op_next = OP_CLR;
                FN_COMPARE_MEMORY: op_next = OP_CMP;
                FN_BRANCH_THEN_HALT: op_next = OP_BAH;
                default: op_next = OP_IDLE;
            endcase
        end
    end

    // Effective shift count; saturates so a huge index cannot wrap to a short shift
    logic [INDEX_W:0] count_sum;
    logic [CNT_W:0] effective_shift_count;
    logic [STATE_W-1:0] state_operand;

    always_comb begin
        count_sum = {{(INDEX_W + 1 - CNT_W){1'b0}}, count_field};
        if (index_en) begin
            count_sum = count_sum + {1'b0, selected_index};
        end
        if (count_sum > (INDEX_W + 1)'({(CNT_W + 1){1'b1}})) begin
            effective_shift_count = '1;
        end else begin
            effective_shift_count = count_sum[CNT_W:0];
        end
        state_operand = state_field;
        if (index_en) begin
            state_operand = state_field + selected_index[STATE_W-1:0];
        end
    end

    logic is_shift;
    assign is_shift = (op_next inside {OP_ARS, OP_LRS, OP_ROL, OP_LSL,
                                       OP_DARS, OP_DLRS, OP_DROL, OP_DLSL});

    logic take;
    assign take = start & ~busy & ~halted & (op_next != OP_IDLE);

    // Datapath results for the request being taken
    logic [2*WORD_W-1:0] shifted;
    logic [WORD_W-1:0] acc_next;
    logic [WORD_W-1:0] ext_next;
    logic [FLAGS_W-1:0] flags_next;
    logic [STEPS_W-1:0] cyc_next;

    always_comb begin
        shifted = shift_all(op_next, {acc, ext}, effective_shift_count);
        acc_next = acc;
        ext_next = ext;
        flags_next = flags;
        cyc_next = SINGLE_CYC;
        if (is_shift) begin
            acc_next = shifted[2*WORD_W-1:WORD_W];
            ext_next = shifted[WORD_W-1:0];
            cyc_next = shift_cycles(effective_shift_count);
        end
        case (op_next)
            OP_RUM: begin
                acc_next = (mem_operand & ext) | (acc & ~ext);
                cyc_next = LOGIC_CYC;
            end
            OP_XOR: begin
                acc_next = acc ^ mem_operand;
                cyc_next = LOGIC_CYC;
            end
            OP_AND: begin
                acc_next = acc & mem_operand;
                cyc_next = LOGIC_CYC;
            end
            OP_OR: begin
                acc_next = acc | mem_operand;
                cyc_next = LOGIC_CYC;
            end
            OP_SET: flags_next[OV_BIT:SENSE_LO] = flags[OV_BIT:SENSE_LO] | state_operand;
            OP_CLR: flags_next[OV_BIT:SENSE_LO] = flags[OV_BIT:SENSE_LO] & ~state_operand;
            OP_CMP: begin
                flags_next[FL_GT] = $signed(acc) > $signed(mem_operand);
                flags_next[FL_EQ] = acc == mem_operand;
                flags_next[FL_LT] = $signed(acc) < $signed(mem_operand);
                flags_next[FL_BM] = |(acc & mem_operand);
                cyc_next = COMPARE_CYC;
            end
            OP_BRU: begin
                if (indirect) begin
                    flags_next[OV_BIT] = mem_operand[RESTORE_OV];
                    flags_next[FL_GT] = mem_operand[RESTORE_GT];
                    flags_next[FL_LT] = mem_operand[RESTORE_LT];
                    flags_next[FL_EQ] = mem_operand[RESTORE_EQ];
                    flags_next[FL_BM] = mem_operand[RESTORE_BM];
                end
            end
            default: begin
                cyc_next = is_shift ? cyc_next : SINGLE_CYC;
            end
        endcase
    end

    // Working registers; execution wins over a register write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc <= WORD_RST;
            ext <= WORD_RST;
            flags <= FLAGS_RST;
        end else if (take) begin
            acc <= acc_next;
            ext <= ext_next;
            flags <= flags_next;
        end else if (reg_wr) begin
            if (reg_addr == REG_ACC) begin
                acc <= reg_wdata;
            end
            if (reg_addr == REG_EXT) begin
                ext <= reg_wdata;
            end
            if (reg_addr == REG_FLAGS) begin
                flags <= reg_wdata[FLAGS_W-1:0];
            end
        end
    end

    // Cycle timing of the instruction
    logic [STEPS_W-1:0] remain_reg;
    logic branch_pend_reg;
    logic halt_pend_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
            remain_reg <= '0;
        end else begin
            done <= 1'b0;
            if (take) begin
                if (cyc_next == SINGLE_CYC) begin
                    done <= 1'b1;
                end else begin
                    busy <= 1'b1;
                    remain_reg <= cyc_next - SINGLE_CYC;
                end
            end else if (busy) begin
                if (remain_reg == SINGLE_CYC) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remain_reg <= remain_reg - SINGLE_CYC;
                end
            end
        end
    end

    // Transfer of control and halt
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            branch_take <= 1'b0;
            branch_addr <= '0;
            halted <= 1'b0;
        end else begin
            branch_take <= 1'b0;
            if (take && (op_next == OP_BRU || op_next == OP_BAH)) begin
                branch_take <= 1'b1;
                branch_addr <= eff_addr;
            end
            if (take && op_next == OP_BAH) begin
                halted <= 1'b1;
            end else if (halted && sw_press) begin
                halted <= 1'b0;
            end
        end
    end

    // Register read, data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata <= WORD_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_FLAGS: reg_rdata <= WORD_W'(flags);
                REG_ACC: reg_rdata <= acc;
                REG_EXT: reg_rdata <= ext;
                REG_STATUS: reg_rdata <= WORD_W'({halted, busy});
                default: reg_rdata <= WORD_RST;
            endcase
        end else begin
            reg_rdata <= WORD_RST;
        end
    end

endmodule : exec_unit

`default_nettype wire

// *** exec_unit_sva.sv ***
// Port checker for exec_unit: results of each request except or, compare less-than and all shifts but an unindexed arithmetic right by 7;
// timing of those except masked replace and branch then halt.
// Assumes requests come from an idle unit; attached to every exec_unit by bind.
`timescale 1ns/1ps
`default_nettype none
module exec_unit_sva
    import exec_unit_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire logic [5:0] opcode,
    input wire func_t func,
    input wire logic [CNT_W-1:0] count_field,
    input wire logic [STATE_W-1:0] state_field,
    input wire logic index_en,
    input wire logic [INDEX_W-1:0] selected_index,
    input wire logic indirect,
    input wire logic [ADDR_W-1:0] eff_addr,
    input wire logic [WORD_W-1:0] mem_operand,
    // Results
    input wire logic done,
    input wire logic busy,
    input wire logic branch_take,
    input wire logic [ADDR_W-1:0] branch_addr,
    input wire logic halted,
    input wire logic [WORD_W-1:0] acc,
    input wire logic [WORD_W-1:0] ext,
    input wire logic [FLAGS_W-1:0] flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic go;
    logic fgo;
    logic [STATE_W-1:0] st_op;
    assign go = start && !busy && !halted;
    // Function codes only count when the major opcode is not decoded here
    assign fgo = go && !(opcode inside {OPC_BRANCH, OPC_XOR, OPC_AND, OPC_OR});
    assign st_op = state_field + (index_en ? selected_index[STATE_W-1:0] : 10'h000);

    bru_take_a: assert property (
        go && opcode == OPC_BRANCH |=> done && branch_take && branch_addr == $past(eff_addr))
        else $error("branch not taken in one cycle");
    bru_restore_a: assert property (
        go && opcode == OPC_BRANCH && indirect |=> {flags[OV_BIT], flags[FL_GT], flags[FL_LT],
        flags[FL_EQ], flags[FL_BM]} == $past(mem_operand[RESTORE_OV:RESTORE_BM]))
        else $error("indicators not restored");
    xor_acc_a: assert property (
        go && opcode == OPC_XOR |=> acc == ($past(acc) ^ $past(mem_operand)) && busy ##1 done)
        else $error("xor result or timing wrong");
    and_acc_a: assert property (
        go && opcode == OPC_AND |-> ##2 done && acc == ($past(acc, 2) & $past(mem_operand, 2)))
        else $error("and result or timing wrong");
    mask_acc_a: assert property (
        fgo && func == FN_MASKED_REPLACE |=> ext == $past(ext) && acc ==
        (($past(mem_operand) & $past(ext)) | ($past(acc) & ~$past(ext))))
        else $error("masked replace wrong");
    cmp_flags_a: assert property (
        fgo && func == FN_COMPARE_MEMORY |=> flags[FL_BM] == |($past(acc) & $past(mem_operand))
        && flags[FL_EQ] == ($past(acc) == $past(mem_operand))
        && flags[FL_GT] == ($signed($past(acc)) > $signed($past(mem_operand))) ##1 done)
        else $error("compare indicators wrong");
    set_state_a: assert property (
        fgo && func == FN_SET_STATE_OP |=> done
        && flags[OV_BIT:0] == ($past(flags[OV_BIT:0]) | $past(st_op)))
        else $error("set state wrong");
    clr_state_a: assert property (
        fgo && func == FN_CLEAR_STATE_OP |=> done
        && flags[OV_BIT:0] == ($past(flags[OV_BIT:0]) & ~$past(st_op)))
        else $error("clear state wrong");
    halt_set_a: assert property (
        fgo && func == FN_BRANCH_THEN_HALT |=> halted && branch_take
        && branch_addr == $past(eff_addr))
        else $error("branch then halt wrong");
    ars_shift_a: assert property (
        fgo && func == FN_ARITH_RIGHT_SHIFT && !index_en && count_field == 6'h07
        |=> acc == {{7{$past(acc[23])}}, $past(acc[23:7])} ##1 done)
        else $error("arithmetic shift wrong");
endmodule : exec_unit_sva

bind exec_unit exec_unit_sva sva_i (.*);
`default_nettype wire

// *** operand_memory.sv ***
// Memory data path model: a small word store that presents the operand.
// Assumes the bench loads words before issuing and fetches in the start cycle.
`timescale 1ns/1ps
`default_nettype none
module operand_memory
    import exec_unit_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Loading
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire logic [WORD_W-1:0] wr_data,
    // Fetch
    input wire logic rd_en,
    output logic [WORD_W-1:0] rd_data
);
    logic [WORD_W-1:0] words [16];
    logic [WORD_W-1:0] last_reg = 24'h5A_A55A;
    always @(posedge ref_clk) begin
        if (wr_en) begin
            words[addr] <= wr_data;
        end
        last_reg <= rd_en ? ~words[addr] : ~last_reg;
    end
    // Outside a fetch the bus is not held, so stale data must not linger
    assign rd_data = rd_en ? words[addr] : last_reg;
endmodule : operand_memory
`default_nettype wire

// *** shift_logic_compare_branch_unit_tb_top.sv ***
// Testbench for exec_unit: scenario tasks drive the sequencer and register ports.
// Assumes operand_memory supplies operands and exec_unit_sva is bound.
`timescale 1ns/1ps
`default_nettype none
module shift_logic_compare_branch_unit_tb_top import exec_unit_pkg::*;;
    logic ref_clk, nrst, start, index_en, indirect, start_switch, reg_wr, reg_rd;
    logic m_wr, m_rd, busy, done, branch_take, halted;
    logic [5:0] opcode;
    func_t func;
    logic [CNT_W-1:0] count_field;
    logic [STATE_W-1:0] state_field;
    logic [INDEX_W-1:0] selected_index;
    logic [ADDR_W-1:0] eff_addr, branch_addr;
    logic [WORD_W-1:0] mem_operand, reg_wdata, reg_rdata, acc, ext, m_wdata;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [3:0] m_addr;
    logic [FLAGS_W-1:0] flags;
    int miscompares, tests_run;

    exec_unit DUT (.*);
    operand_memory MEM (.ref_clk(ref_clk), .wr_en(m_wr), .addr(m_addr), .wr_data(m_wdata),
        .rd_en(m_rd), .rd_data(mem_operand));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic check_w(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_w

    task automatic check_n(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            miscompares++;
            $display("ERROR at %0t: cycles %h expected %h", $time, got, exp);
        end
    endtask : check_n

    task automatic reg_w(input logic [REG_ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_w

    task automatic reg_r(input logic [REG_ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask : reg_r

    task automatic mem_w(input logic [3:0] a, input logic [WORD_W-1:0] d);
        @(posedge ref_clk);
        m_wr <= 1'b1;
        m_addr <= a;
        m_wdata <= d;
        @(posedge ref_clk);
        m_wr <= 1'b0;
    endtask : mem_w

    // Returns cycles from the taking edge to done; 40 means nothing finished
    task automatic issue(input logic [5:0] opc, input func_t fn, input logic [3:0] ma,
            output int cyc);
        @(posedge ref_clk);
        opcode <= opc;
        func <= fn;
        m_addr <= ma;
        m_rd <= 1'b1;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        m_rd <= 1'b0;
        cyc = 0;
        do begin
            @(posedge ref_clk);
            cyc++;
        end while (done !== 1'b1 && cyc < 40);
    endtask : issue

    function automatic logic [47:0] step(input func_t f, input logic [47:0] x);
        case (f)
            FN_ARITH_RIGHT_SHIFT: return {x[47], x[47:25], x[23:0]};
            FN_LOGICAL_RIGHT_SHIFT: return {1'b0, x[47:25], x[23:0]};
            FN_ROTATE_LEFT: return {x[46:24], x[47], x[23:0]};
            FN_END_OFF_LEFT_SHIFT: return {x[46:24], 1'b0, x[23:0]};
            FN_DOUBLE_ARITH_RIGHT: return {x[47], x[47:1]};
            FN_DOUBLE_LOGICAL_RIGHT_SHIFT: return {1'b0, x[47:1]};
            FN_DOUBLE_ROTATE_LEFT: return {x[46:0], x[47]};
            default: return {x[46:0], 1'b0};
        endcase
    endfunction : step

    task automatic t_regs;
        logic [WORD_W-1:0] d;
        reg_w(REG_ACC, 24'hA5_C3F1);
        reg_w(REG_STATUS, 24'hFF_FFFF);
        reg_w(4'h9, 24'h12_3456);
        reg_r(REG_ACC, d);
        check_w(d, 24'hA5_C3F1);
        reg_r(REG_STATUS, d);
        check_w(d, 24'h00_0000);
        reg_r(4'h9, d);
        check_w(d, 24'h00_0000);
    endtask : t_regs

    task automatic t_logic;
        logic [5:0] opc [3];
        logic [WORD_W-1:0] a, m, e;
        int c;
        opc = '{OPC_XOR, OPC_AND, OPC_OR};
        a = 24'h3C_5A96;
        m = 24'h0F_F0A5;
        mem_w(4'h1, m);
        for (int i = 0; i < 3; i++) begin
            reg_w(REG_ACC, a);
            issue(opc[i], FN_NONE, 4'h1, c);
            e = (i == 0) ? a ^ m : (i == 1) ? a & m : a | m;
            check_w(acc, e);
            check_n(c, 2);
        end
        reg_w(REG_EXT, 24'h0F_0F0F);
        mem_w(4'h1, 24'h33_CC55);
        issue(6'h00, FN_MASKED_REPLACE, 4'h1, c);
        check_w(acc, 24'h33_CC55 & 24'h0F_0F0F | (a | m) & 24'hF0_F0F0);
        check_w(ext, 24'h0F_0F0F);
    endtask : t_logic

    task automatic t_shift;
        logic [47:0] ae;
        int c;
        int n;
        for (int p = 0; p < 2; p++) begin
            for (int f = 1; f <= 8; f++) begin
                reg_w(REG_ACC, 24'hA5_C3F1);
                reg_w(REG_EXT, 24'h3C_0F96);
                count_field <= p ? 6'h0F : 6'h07;
                index_en <= p[0];
                selected_index <= 14'h0004;
                n = p ? 19 : 7;
                issue(6'h00, func_t'(f), 4'h0, c);
                ae = {24'hA5_C3F1, 24'h3C_0F96};
                repeat (n) ae = step(func_t'(f), ae);
                check_w(acc, ae[47:24]);
                check_w(ext, ae[23:0]);
                check_n(c, p ? 4 : 2);
            end
        end
        index_en <= 1'b0;
    endtask : t_shift

    task automatic t_state;
        int c;
        reg_w(REG_FLAGS, 24'h00_0081);
        state_field <= 10'h3F0;
        index_en <= 1'b1;
        selected_index <= 14'h0015;
        issue(6'h00, FN_SET_STATE_OP, 4'h0, c);
        check_w({14'h0000, flags[9:0]}, 24'h00_0085);
        check_n(c, 1);
        index_en <= 1'b0;
        state_field <= 10'h281;
        issue(6'h00, FN_CLEAR_STATE_OP, 4'h0, c);
        check_w({14'h0000, flags[9:0]}, 24'h00_0004);
    endtask : t_state

    task automatic t_cmp;
        logic [WORD_W-1:0] m [4];
        logic [WORD_W-1:0] a;
        logic [3:0] e;
        int c;
        m = '{24'h00_0F00, 24'h00_0F0F, 24'h10_0000, 24'hF0_00F0};
        a = 24'h00_0F0F;
        reg_w(REG_ACC, a);
        for (int i = 0; i < 4; i++) begin
            mem_w(4'h2, m[i]);
            issue(6'h00, FN_COMPARE_MEMORY, 4'h2, c);
            e = {|(a & m[i]), $signed(a) < $signed(m[i]), a == m[i], $signed(a) > $signed(m[i])};
            check_w({20'h0_0000, flags[13:10]}, {20'h0_0000, e});
            check_n(c, 2);
        end
    endtask : t_cmp

    task automatic t_branch;
        int c;
        mem_w(4'h3, 24'hA8_0000);
        indirect <= 1'b1;
        eff_addr <= 14'h1234;
        issue(OPC_BRANCH, FN_NONE, 4'h3, c);
        indirect <= 1'b0;
        check_w({10'h000, branch_addr}, 24'h00_1234);
        check_n(c, 1);
        check_w({19'h0_0000, flags[OV_BIT], flags[FL_GT], flags[FL_LT], flags[FL_EQ],
            flags[FL_BM]}, 24'h00_0015);
        eff_addr <= 14'h0ABC;
        issue(6'h00, FN_BRANCH_THEN_HALT, 4'h0, c);
        check_w({23'h00_0000, halted}, 24'h00_0001);
        check_w({10'h000, branch_addr}, 24'h00_0ABC);
        reg_w(REG_ACC, 24'h00_00FF);
        issue(OPC_XOR, FN_NONE, 4'h3, c);
        check_w(acc, 24'h00_00FF);
        start_switch <= 1'b1;
        for (int i = 0; i < 10 && halted === 1'b1; i++) @(posedge ref_clk);
        start_switch <= 1'b0;
        check_w({23'h00_0000, halted}, 24'h00_0000);
    endtask : t_branch

    initial begin
        {nrst, start, index_en, indirect, start_switch, reg_wr, reg_rd, m_wr, m_rd} = '0;
        {opcode, count_field, state_field, selected_index, eff_addr} = '0;
        {reg_wdata, m_wdata, reg_addr, m_addr} = '0;
        func = FN_NONE;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs;
        t_logic;
        t_shift;
        t_state;
        t_cmp;
        t_branch;
        stop_test;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test;
    end
endmodule : shift_logic_compare_branch_unit_tb_top
`default_nettype wire
